/* include/acsc_pkg.sv */
// package: register map, field layout and states of the channel sequencing configuration block
package acsc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PIN_LEVEL   = 8'h0D;
    localparam logic [7:0] ADDR_HOLDOFF_CFG = 8'h0F;
    localparam logic [7:0] ADDR_SEQ_CFG     = 8'h10;
    localparam logic [7:0] ADDR_CH_CHOICE   = 8'h11;
    localparam logic [7:0] ADDR_SCAN_MASK   = 8'h12;
    localparam logic [7:0] ADDR_ALERT_MASK  = 8'h14;
    localparam logic [7:0] REG_RESET        = 8'h00;
    localparam logic [7:0] SEQ_CFG_WMASK    = 8'h13;
    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int         NUM_CH           = 8;
    localparam int         HOLDOFF_MULT_BIT = 7;
    localparam int         HOLDOFF_SHIFT    = 3;
    localparam int         HOLDOFF_W        = 10;
    localparam int         SEQUENCE_START_BIT_BIT    = 4;
    localparam int         SRC_LSB          = 4;
    localparam logic [1:0] MODE_MANUAL      = 2'h0;
    localparam logic [1:0] MODE_AUTO        = 2'h1;
    localparam logic [3:0] CH_LAST_VALID    = 4'h7;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic {
        ACSC_SEQ_IDLE,
        ACSC_SEQ_RUN
    } acsc_seq_state_t;
endpackage

/* include/acsc_core_if.sv */
// interface: signals shared between the top, the sequencer and the hold-off counter
`timescale 1ns/1ps
`default_nettype none
interface acsc_core_if;
    logic       ce;
    logic [1:0] mode;
    logic       start;
    logic [7:0] scan_mask;
    logic [3:0] manual_ch;
    logic       conv_done;
    logic [3:0] channel;
    logic       active;
    logic       zc_sig;
    logic       zc_conv;
    logic [7:0] holdoff_cfg;
    logic       zc_event;
    logic       blanking;
    modport top  (output ce, mode, start, scan_mask, manual_ch, conv_done,
                  zc_sig, zc_conv, holdoff_cfg,
                  input channel, active, zc_event, blanking);
    modport seq  (input ce, mode, start, scan_mask, manual_ch, conv_done,
                  output channel, active);
    modport hold (input ce, zc_sig, zc_conv, holdoff_cfg,
                  output zc_event, blanking);
endinterface
`default_nettype wire

/* rtl/acsc_seq.sv */
// channel sequencer: manual choice or ascending scan of masked channels
`timescale 1ns/1ps
`default_nettype none
module acsc_seq
    import acsc_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    acsc_core_if.seq        bus
);
    acsc_seq_state_t state;
    acsc_seq_state_t next_state;
    logic [3:0]      channel;
    logic [3:0]      next_channel;
    logic            auto_on;
    logic            active;
    logic            next_active;

    // next enabled channel above cur, wrapping past the top
    function automatic logic [3:0] next_after(input logic [2:0] cur, input logic [7:0] mask);
        logic [2:0] idx;
        next_after = {1'b0, cur};
        for (int j = NUM_CH; j >= 1; j--) begin
            idx = 3'(int'(cur) + j);
            if (mask[idx]) begin
                next_after = {1'b0, idx};
            end
        end
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        auto_on      = (bus.mode == MODE_AUTO) && bus.start && (bus.scan_mask != 8'h00);
        next_state   = state;
        next_channel = channel;
        case (state)
            ACSC_SEQ_IDLE: begin
                if (auto_on) begin
                    next_state   = ACSC_SEQ_RUN;
                    next_channel = next_after(3'h7, bus.scan_mask);
                end else if (bus.mode == MODE_MANUAL) begin
                    next_channel = bus.manual_ch;
                end
            end
            ACSC_SEQ_RUN: begin
                if (!auto_on) begin
                    next_state = ACSC_SEQ_IDLE;
                end else if (bus.conv_done) begin
                    next_channel = next_after(channel[2:0], bus.scan_mask);
                end
            end
            default: begin
                next_state = ACSC_SEQ_IDLE;
            end
        endcase
        // registered so the top output comes straight from a flop
        next_active = (next_state == ACSC_SEQ_RUN);
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state   <= ACSC_SEQ_IDLE;
            channel <= 4'h0;
            active  <= 1'b0;
        end else if (bus.ce) begin
            state   <= next_state;
            channel <= next_channel;
            active  <= next_active;
        end
    end

    assign bus.channel = channel;
    assign bus.active  = active;

    stop_leaves_run_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (bus.ce && state == ACSC_SEQ_RUN && !auto_on) |=> state == ACSC_SEQ_IDLE)
        else $error("sequencer kept running after stop");
    manual_choice_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (bus.ce && state == ACSC_SEQ_IDLE && bus.mode == MODE_MANUAL)
        |=> channel == $past(bus.manual_ch))
        else $error("manual channel not taken");
    scan_first_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (bus.ce && state == ACSC_SEQ_IDLE && auto_on)
        |=> state == ACSC_SEQ_RUN && (($past(bus.scan_mask) >> channel[2:0]) & 8'h01) == 8'h01)
        else $error("scan began on a masked channel");
endmodule
`default_nettype wire

/* rtl/acsc_holdoff.sv */
// zero-crossing event detector with conversion-counted hold-off
`timescale 1ns/1ps
`default_nettype none
module acsc_holdoff
    import acsc_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    acsc_core_if.hold       bus
);
    logic                 zc_prev;
    logic                 next_zc_prev;
    logic [HOLDOFF_W-1:0] count;
    logic [HOLDOFF_W-1:0] next_count;
    logic [HOLDOFF_W-1:0] load_val;
    logic                 zc_event;
    logic                 next_zc_event;
    logic                 blanking;
    logic                 next_blanking;

    always_comb begin
        load_val = bus.holdoff_cfg[HOLDOFF_MULT_BIT]
                 ? {bus.holdoff_cfg[6:0], 3'h0}
                 : {3'h0, bus.holdoff_cfg[6:0]};
        next_zc_prev  = bus.zc_sig;
        next_zc_event = 1'b0;
        next_count    = count;
        // a rising crossing counts only once the hold-off has run out
        if (bus.zc_sig && !zc_prev && count == '0) begin
            next_zc_event = 1'b1;
            next_count    = load_val;
        end else if (bus.zc_conv && count != '0) begin
            next_count = count - HOLDOFF_W'(1);
        end
        next_blanking = (next_count != '0);
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            zc_prev  <= 1'b0;
            count    <= '0;
            zc_event <= 1'b0;
            blanking <= 1'b0;
        end else if (bus.ce) begin
            zc_prev  <= next_zc_prev;
            count    <= next_count;
            zc_event <= next_zc_event;
            blanking <= next_blanking;
        end
    end

    assign bus.zc_event = zc_event;
    assign bus.blanking = blanking;

    holdoff_blocks_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (bus.ce && count != '0) |=> !zc_event)
        else $error("event raised during hold-off");
    holdoff_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (bus.ce && zc_event && $past(bus.ce)) |-> count == ($past(bus.holdoff_cfg[7])
            ? {$past(bus.holdoff_cfg[6:0]), 3'h0} : {3'h0, $past(bus.holdoff_cfg[6:0])}))
        else $error("hold-off count loaded wrong");
endmodule
`default_nettype wire

/* rtl/acsc_top.sv */
// top: configuration registers, pin readback, zero-crossing source and alert gating
`timescale 1ns/1ps
`default_nettype none
module acsc_top
    import acsc_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_ce,
    // register port from the serial interface front end
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_rd,
    output logic      [7:0] o_reg_rdata,
    // channel pins and pin configuration
    input  wire logic [7:0] i_pin_level,
    input  wire logic [7:0] i_pin_function,
    input  wire logic [7:0] i_pin_dir_out,
    input  wire logic [7:0] i_analog_zc,
    // conversion engine
    input  wire logic       i_conversion_mode_field,
    input  wire logic       i_host_conv_req,
    input  wire logic       i_conv_busy,
    input  wire logic       i_conv_done,
    output logic            o_conv_start,
    output logic      [3:0] o_conv_channel,
    output logic            o_seq_active,
    // zero-crossing and alert
    output logic            o_zc_event,
    output logic            o_zc_blanking,
    input  wire logic [7:0] i_alert_flags,
    output logic            o_alert
);
    acsc_core_if core ();

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [7:0] holdoff_cfg;
    logic [7:0] seq_cfg;
    logic [7:0] ch_choice;
    logic [7:0] scan_mask;
    logic [7:0] alert_mask;
    logic [7:0] next_holdoff_cfg;
    logic [7:0] next_seq_cfg;
    logic [7:0] next_ch_choice;
    logic [7:0] next_scan_mask;
    logic [7:0] next_alert_mask;

    always_comb begin
        next_holdoff_cfg = holdoff_cfg;
        next_seq_cfg     = seq_cfg;
        next_ch_choice   = ch_choice;
        next_scan_mask   = scan_mask;
        next_alert_mask  = alert_mask;
        if (i_reg_wr) begin
            case (i_reg_addr)
                ADDR_HOLDOFF_CFG: next_holdoff_cfg = i_reg_wdata;
                ADDR_SEQ_CFG:     next_seq_cfg     = i_reg_wdata & SEQ_CFG_WMASK;
                ADDR_CH_CHOICE:   next_ch_choice   = i_reg_wdata;
                ADDR_SCAN_MASK:   next_scan_mask   = i_reg_wdata;
                ADDR_ALERT_MASK:  next_alert_mask  = i_reg_wdata;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            holdoff_cfg <= REG_RESET;
            seq_cfg     <= REG_RESET;
            ch_choice   <= REG_RESET;
            scan_mask   <= REG_RESET;
            alert_mask  <= REG_RESET;
        end else if (i_ce) begin
            holdoff_cfg <= next_holdoff_cfg;
            seq_cfg     <= next_seq_cfg;
            ch_choice   <= next_ch_choice;
            scan_mask   <= next_scan_mask;
            alert_mask  <= next_alert_mask;
        end
    end

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
        end else if (i_ce) begin
            pin_meta <= i_pin_level;
            pin_sync <= pin_meta;
        end
    end

    // ------------------------------------------------------------
    // zero-crossing source
    // ------------------------------------------------------------
    logic [3:0] zc_src;
    logic       zc_src_valid;
    logic       zc_digital;
    logic       zc_sig;

    always_comb begin
        zc_src       = ch_choice[7:SRC_LSB];
        zc_src_valid = (zc_src <= CH_LAST_VALID);
        // a digital input is a general-purpose pin not driven as output
        zc_digital   = i_pin_function[zc_src[2:0]] && !i_pin_dir_out[zc_src[2:0]];
        if (!zc_src_valid) begin
            zc_sig = 1'b0;
        end else if (zc_digital) begin
            zc_sig = pin_sync[zc_src[2:0]];
        end else begin
            zc_sig = i_analog_zc[zc_src[2:0]];
        end
    end

    // ------------------------------------------------------------
    // submodule hookup
    // ------------------------------------------------------------
    assign core.ce          = i_ce;
    assign core.mode        = seq_cfg[1:0];
    assign core.start       = seq_cfg[SEQUENCE_START_BIT_BIT];
    assign core.scan_mask   = scan_mask;
    assign core.manual_ch   = ch_choice[3:0];
    assign core.conv_done   = i_conv_done;
    assign core.zc_sig      = zc_sig;
    assign core.zc_conv     = i_conv_done && zc_src_valid && (o_conv_channel == zc_src);
    assign core.holdoff_cfg = holdoff_cfg;

    acsc_seq u_seq (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .bus       (core)
    );

    acsc_holdoff u_holdoff (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .bus       (core)
    );

    assign o_conv_channel = core.channel;
    assign o_seq_active   = core.active;
    assign o_zc_event     = core.zc_event;
    assign o_zc_blanking  = core.blanking;

    // ------------------------------------------------------------
    // read data, conversion launch and alert
    // ------------------------------------------------------------
    logic [7:0] next_rdata;
    logic       next_conv_start;
    logic       next_alert;

    always_comb begin
        next_rdata = o_reg_rdata;
        if (i_reg_rd) begin
            case (i_reg_addr)
                ADDR_PIN_LEVEL:   next_rdata = pin_sync;
                ADDR_HOLDOFF_CFG: next_rdata = holdoff_cfg;
                ADDR_SEQ_CFG:     next_rdata = seq_cfg & SEQ_CFG_WMASK;
                ADDR_CH_CHOICE:   next_rdata = ch_choice;
                ADDR_SCAN_MASK:   next_rdata = scan_mask;
                ADDR_ALERT_MASK:  next_rdata = alert_mask;
                default:          next_rdata = 8'h00;
            endcase
        end
        // internal launch fires every other idle cycle so busy can rise in between
        if (i_conversion_mode_field) begin
            next_conv_start = !i_conv_busy && !o_conv_start;
        end else begin
            next_conv_start = i_host_conv_req;
        end
        next_alert = |(i_alert_flags & alert_mask);
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata  <= 8'h00;
            o_conv_start <= 1'b0;
            o_alert      <= 1'b0;
        end else if (i_ce) begin
            o_reg_rdata  <= next_rdata;
            o_conv_start <= next_conv_start;
            o_alert      <= next_alert;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    pin_readback_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && i_reg_rd && i_reg_addr == ADDR_PIN_LEVEL) |=> o_reg_rdata == $past(pin_sync))
        else $error("pin level readback wrong");
    seq_reserved_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && i_reg_rd && i_reg_addr == ADDR_SEQ_CFG) |=> (o_reg_rdata & 8'hEC) == 8'h00)
        else $error("reserved sequencing bits read nonzero");
    alert_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && (i_alert_flags & alert_mask) == 8'h00) |=> !o_alert)
        else $error("alert raised by a masked channel");
endmodule
`default_nettype wire

/* test/acsc_host_model.sv */
// host model: drives the register port with single-byte writes and reads
`timescale 1ns/1ps
`default_nettype none
module acsc_host_model (
    input  wire logic       i_ref_clk,
    input  wire logic [7:0] i_reg_rdata,
    output logic      [7:0] o_reg_addr,
    output logic            o_reg_wr,
    output logic      [7:0] o_reg_wdata,
    output logic            o_reg_rd
);
    initial begin
        o_reg_addr  = 8'h00;
        o_reg_wr    = 1'b0;
        o_reg_wdata = 8'h00;
        o_reg_rd    = 1'b0;
    end
    // ------------------------------------------------------------
    // register cycles
    // ------------------------------------------------------------
    // strobe lasts one edge; the next call waits an edge, so strobes never merge
    // callers never pick a general-purpose channel for a manual conversion
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_ref_clk);
        o_reg_addr  <= addr;
        o_reg_wdata <= data;
        o_reg_wr    <= 1'b1;
        @(posedge i_ref_clk);
        o_reg_wr    <= 1'b0;
    endtask
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge i_ref_clk);
        o_reg_addr <= addr;
        o_reg_rd   <= 1'b1;
        @(posedge i_ref_clk);
        o_reg_rd   <= 1'b0;
        @(negedge i_ref_clk);
        data = i_reg_rdata;
    endtask
endmodule
`default_nettype wire

/* test/adc_channel_sequence_config_tb.sv */
// testbench: register map, sequencing, zero-crossing hold-off and alert gating
`timescale 1ns/1ps
`default_nettype none
module adc_channel_sequence_config_tb;
    import acsc_pkg::*;
    logic       clk = 1'b0, rst_n = 1'b0, conversion_mode_field = 1'b0, host_req = 1'b0;
    logic       busy = 1'b0, done = 1'b0, conv_start, seq_active, zc_event, blanking, alert;
    logic [7:0] pin_level = 8'h00, pin_fn = 8'h00, azc = 8'h00, flags = 8'h00, pin_dir = 8'h00;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
    logic       reg_wr, reg_rd;
    logic [3:0] conv_ch;
    int         bad_count = 0, samples_checked = 0, cycles = 0, zc_cnt = 0, start_cnt = 0;
    logic [7:0] addrs [6] = '{ADDR_PIN_LEVEL, ADDR_HOLDOFF_CFG, ADDR_SEQ_CFG,
                              ADDR_CH_CHOICE, ADDR_SCAN_MASK, ADDR_ALERT_MASK};
    always #50 clk = ~clk;
    acsc_host_model host (.i_ref_clk(clk), .i_reg_rdata(reg_rdata), .o_reg_addr(reg_addr),
        .o_reg_wr(reg_wr), .o_reg_wdata(reg_wdata), .o_reg_rd(reg_rd));
    acsc_top DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_reg_addr(reg_addr),
        .i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd),
        .o_reg_rdata(reg_rdata), .i_pin_level(pin_level), .i_pin_function(pin_fn),
        .i_pin_dir_out(pin_dir), .i_analog_zc(azc), .i_conversion_mode_field(conversion_mode_field),
        .i_host_conv_req(host_req), .i_conv_busy(busy), .i_conv_done(done),
        .o_conv_start(conv_start), .o_conv_channel(conv_ch), .o_seq_active(seq_active),
        .o_zc_event(zc_event), .o_zc_blanking(blanking), .i_alert_flags(flags),
        .o_alert(alert));
    // ------------------------------------------------------------
    // monitors and helpers
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (zc_event === 1'b1) zc_cnt++;
        if (conv_start === 1'b1) start_cnt++;
        if (cycles == 5000) begin
            bad_count++;
            results();
        end
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse_done();
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        @(negedge clk);
    endtask
    // rising edge on channel 3, held long enough to pass the pin synchroniser
    task automatic pulse_zc(input logic dig);
        @(posedge clk);
        if (dig) pin_level <= 8'h08;
        else azc <= 8'h08;
        repeat (4) @(posedge clk);
        pin_level <= 8'h00;
        azc       <= 8'h00;
        tick(3);
    endtask
    task automatic results();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        foreach (addrs[i]) begin
            host.read_reg(addrs[i], rd_val);
            check("reset value", rd_val, REG_RESET);
        end
        check("reset channel", {4'h0, conv_ch}, 8'h00);
        check("reset active", {7'h00, seq_active}, 8'h00);
    endtask
    task automatic t_rw();
        for (int i = 1; i < 6; i++) host.write_reg(addrs[i], 8'hFF);
        for (int i = 1; i < 6; i++) begin
            host.read_reg(addrs[i], rd_val);
            check("rw value", rd_val, (addrs[i] == ADDR_SEQ_CFG) ? 8'h13 : 8'hFF);
        end
        check("mode 11 active", {7'h00, seq_active}, 8'h00);
        host.write_reg(8'h13, 8'hFF);
        host.read_reg(8'h13, rd_val);
        check("unmapped", rd_val, 8'h00);
        for (int i = 1; i < 6; i++) host.write_reg(addrs[i], 8'h00);
    endtask
    task automatic t_pins();
        @(posedge clk);
        pin_level <= 8'h5A;
        tick(3);
        host.read_reg(ADDR_PIN_LEVEL, rd_val);
        check("pin level", rd_val, 8'h5A);
        @(posedge clk);
        pin_level <= 8'h00;
        host.write_reg(ADDR_CH_CHOICE, 8'h07);
        tick(2);
        check("manual channel", {4'h0, conv_ch}, 8'h07);
    endtask
    task automatic t_seq();
        host.write_reg(ADDR_SCAN_MASK, 8'h05);
        host.write_reg(ADDR_SEQ_CFG, 8'h11);
        tick(2);
        check("seq active", {7'h00, seq_active}, 8'h01);
        check("first channel", {4'h0, conv_ch}, 8'h00);
        pulse_done();
        check("skip channel", {4'h0, conv_ch}, 8'h02);
        pulse_done();
        check("wrap channel", {4'h0, conv_ch}, 8'h00);
        host.write_reg(ADDR_SEQ_CFG, 8'h01);
        tick(2);
        check("seq stop", {7'h00, seq_active}, 8'h00);
        host.write_reg(ADDR_SEQ_CFG, 8'h12);
        tick(2);
        check("mode 10 active", {7'h00, seq_active}, 8'h00);
        host.write_reg(ADDR_SEQ_CFG, 8'h00);
    endtask
    task automatic t_zc();
        host.write_reg(ADDR_HOLDOFF_CFG, 8'h02);
        host.write_reg(ADDR_CH_CHOICE, 8'h33);
        pulse_zc(1'b0);
        check("zc event", zc_cnt[7:0], 8'h01);
        check("blanking on", {7'h00, blanking}, 8'h01);
        pulse_zc(1'b0);
        check("zc dropped", zc_cnt[7:0], 8'h01);
        repeat (2) pulse_done();
        check("blanking off", {7'h00, blanking}, 8'h00);
        host.write_reg(ADDR_HOLDOFF_CFG, 8'h81);
        pulse_zc(1'b0);
        check("zc second", zc_cnt[7:0], 8'h02);
        repeat (7) pulse_done();
        check("x8 blanking", {7'h00, blanking}, 8'h01);
        pulse_done();
        check("x8 done", {7'h00, blanking}, 8'h00);
        host.write_reg(ADDR_HOLDOFF_CFG, 8'h00);
        host.write_reg(ADDR_CH_CHOICE, 8'h30);
        @(posedge clk);
        pin_fn <= 8'h08;
        pulse_zc(1'b0);
        check("analog ignored", zc_cnt[7:0], 8'h02);
        pulse_zc(1'b1);
        check("digital zc", zc_cnt[7:0], 8'h03);
        // a general-purpose pin driven as output is no digital source
        @(posedge clk);
        pin_dir <= 8'h08;
        pulse_zc(1'b1);
        check("output pin ignored", zc_cnt[7:0], 8'h03);
        @(posedge clk);
        pin_fn  <= 8'h00;
        pin_dir <= 8'h00;
    endtask
    task automatic t_alert_conv();
        @(posedge clk);
        flags <= 8'h03;
        host.write_reg(ADDR_ALERT_MASK, 8'h02);
        tick(2);
        check("alert on", {7'h00, alert}, 8'h01);
        @(posedge clk);
        flags <= 8'h01;
        tick(2);
        check("alert gated", {7'h00, alert}, 8'h00);
        @(posedge clk);
        host_req <= 1'b1;
        @(posedge clk);
        host_req <= 1'b0;
        @(negedge clk);
        check("host start", {7'h00, conv_start}, 8'h01);
        @(posedge clk);
        conversion_mode_field <= 1'b1;
        tick(2);
        start_cnt = 0;
        tick(4);
        check("auto starts", start_cnt[7:0], 8'h02);
        @(posedge clk);
        busy <= 1'b1;
        tick(3);
        start_cnt = 0;
        tick(4);
        check("busy starts", start_cnt[7:0], 8'h00);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_rw();
        t_pins();
        t_seq();
        t_zc();
        t_alert_conv();
        results();
    end
endmodule
`default_nettype wire
